// File: include/mpf_cfg.svh
// Purpose: constants of the manchester program frame port
// Assumes: hclk at 50 MHz
// Notes: times in ns, cycle counts derived from them
`ifndef MPF_CFG_SVH
`define MPF_CFG_SVH
`define MPF_CLK_NS 20
`define MPF_DIS_NS 56000
`define MPF_BIT_NS 39000
`define MPF_LOW_NS 1000
`define MPF_NS2CYC_UP(t) (((t) + `MPF_CLK_NS - 1) / `MPF_CLK_NS)
`define MPF_DIS_CYC `MPF_NS2CYC_UP(`MPF_DIS_NS)
`define MPF_BIT_CYC (`MPF_BIT_NS / `MPF_CLK_NS)
`define MPF_LOW_CYC `MPF_NS2CYC_UP(`MPF_LOW_NS)
`define MPF_WIN_PCT 75
`define MPF_TO_PCT 150
`define MPF_PCT 100
`define MPF_TW 12
`define MPF_SYNC_BITS 2
`define MPF_ADDR_BITS 6
`define MPF_DATA_BITS 32
`define MPF_PAY_BITS 26
`define MPF_ECC_BITS 6
`define MPF_CRC_BITS 3
`define MPF_CRC_INIT 3'h7
`define MPF_RD_LEN 12
`define MPF_WR_LEN 44
`define MPF_TX_LEN 34
`define MPF_WR_RW 41
`define MPF_RD_RW 9
`define MPF_WR_ADDR_LSB 35
`define MPF_RD_ADDR_LSB 3
`define MPF_WR_DATA_LSB 3
`define MPF_ECC_OK 2'h0
`define MPF_ECC_BAD 2'h2
`define MPF_CTRL_OFS 8'h00
`define MPF_STAT_OFS 8'h04
`define MPF_IEN_OFS 8'h08
`define MPF_ICLR_OFS 8'h0c
`define MPF_LAST_OFS 8'h10
`define MPF_CTRL_RST 1'b1
`define MPF_HSIZE_WORD 3'h2
`define MPF_EV_WR 0
`define MPF_EV_RD 1
`define MPF_EV_CRC 2
`define MPF_EV_FMT 3
`define MPF_EV_REL 4
`define MPF_EV_N 5
`endif

// File: include/mpf_pkg.sv
// Purpose: types and shared functions of the frame port
// Assumes: mpf_cfg.svh constants
// Notes: crc and ecc used by writer and reader paths
package mpf_pkg;
`include "mpf_cfg.svh"
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_BIT  = 3'h1,
    ST_DONE = 3'h3,
    ST_WAIT = 3'h2,
    ST_TX   = 3'h6
  } mpf_state_t;

  typedef struct packed {
    mpf_state_t st;
    logic line_p;
    logic rel;
    logic [`MPF_TW-1:0] rcnt;
    logic [`MPF_TW-1:0] cnt;
    logic [5:0] lcnt;
    logic [5:0] nb;
    logic [`MPF_WR_LEN-1:0] sh;
    logic [`MPF_CRC_BITS-1:0] crc;
    logic err;
    logic [`MPF_TX_LEN-1:0] tx;
    logic [5:0] tn;
    logic half;
    logic lo;
    logic loe;
    logic ctrl;
    logic [`MPF_EV_N-1:0] sts;
    logic [`MPF_EV_N-1:0] ien;
    logic [7:0] ha;
    logic wpend;
    logic [31:0] rd;
    logic rdy;
    logic irq;
    logic [6:0] last;
    logic [63:0] vld;
  } mpf_core_t;

  typedef struct packed {
    logic [2:0] ff;
    logic q;
  } mpf_sync_t;

  function automatic logic [2:0] crc_step(input logic [2:0] c, input logic b);
    logic fb;
    fb = c[2] ^ b;
    return {c[1], c[0] ^ fb, fb};
  endfunction

  function automatic logic [`MPF_ECC_BITS-1:0] ecc_gen(input logic [`MPF_PAY_BITS-1:0] d);
    logic [`MPF_ECC_BITS-1:0] e;
    logic [4:0] p;
    e = '0;
    for (int j = 0; j < `MPF_PAY_BITS; j++) begin
      p = 5'(j + 1);
      for (int k = 0; k < 5; k++) begin
        if (p[k]) e[k] = e[k] ^ d[j];
      end
    end
    e[`MPF_ECC_BITS-1] = ^d;
    return e;
  endfunction
endpackage

// File: core/mpf_sync.sv
// Purpose: three-stage synchroniser for pin inputs
// Assumes: input asynchronous to hclk
// Notes: output moves only when stages two and three agree
`timescale 1ns/10ps
module mpf_sync (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic d,
  output logic q
);
  mpf_pkg::mpf_sync_t s_q;
  mpf_pkg::mpf_sync_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.ff = {s_q.ff[1:0], d};
    if (s_q.ff[1] == s_q.ff[2]) s_d.q = s_q.ff[2];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) s_q <= '0;
    else s_q <= s_d;
  end

  assign q = s_q.q;
endmodule // mpf_sync

// File: core/mpf_port.sv
// Purpose: single-wire manchester programming port with ahb-lite status registers
// Assumes: hclk 50 MHz; controller keeps its own frame timing
// Notes: register bus is zero wait state, always okay
// Behaviour
// R1: frames start with two zero sync bits
// R2: direction bit one reads, zero writes
// R3: six-bit address follows direction bit
// R4: data field 32 bits, lsb bit 0
// R5: write stores 25:0, device makes ecc
// R6: reply: 31:28 zero, 27:26 ecc, payload
// R7: three-bit crc ends frame, checked by device
// R8: crc x^3+x+1, init 111, sync excluded
// R9: mid-bit edge, rise zero fall one, msb first
// R10: symbol period 37 to 42 us
// R11: port timing from trimmed internal clock; counted here in hclk cycles
// R12: release driver 512 to 514 clocks after enable
// R13: controller idles line, no late rising edge
// R14: controller waits 144 us before first frame
// R15: controller holds line low 1 us first
// R16: synchronise inputs, decode edges, drop bad crc
// R17: reply is sync plus data after frame
`timescale 1ns/10ps
`include "mpf_cfg.svh"
module mpf_port #(
  parameter int BIT_CYC = `MPF_BIT_CYC,
  parameter int DIS_CYC = `MPF_DIS_CYC,
  parameter int LOW_CYC = `MPF_LOW_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic low_voltage_program_pin,
  input wire logic shared_output_line_i,
  output logic shared_output_line_o,
  output logic shared_output_line_oe,
  output logic irq
);
  localparam int TW = `MPF_TW;
  // all windows are cycles of hclk, standing in for the trimmed port clock // R11
  localparam logic [TW-1:0] C_DIS = TW'(DIS_CYC);
  localparam logic [TW-1:0] C_BIT = TW'(BIT_CYC);
  localparam logic [TW-1:0] C_HALF = TW'(BIT_CYC / 2);
  localparam logic [TW-1:0] C_WIN = TW'(BIT_CYC * `MPF_WIN_PCT / `MPF_PCT);
  localparam logic [TW-1:0] C_TO = TW'(BIT_CYC * `MPF_TO_PCT / `MPF_PCT);
  localparam logic [5:0] C_LOW = 6'(LOW_CYC);
  localparam logic [5:0] L_SYNC = 6'(`MPF_SYNC_BITS);
  localparam logic [5:0] L_RD = 6'(`MPF_RD_LEN);
  localparam logic [5:0] L_WR = 6'(`MPF_WR_LEN);
  localparam logic [5:0] L_TX = 6'(`MPF_TX_LEN);

  mpf_pkg::mpf_core_t s_q;
  mpf_pkg::mpf_core_t s_d;
  logic [31:0] mem [0:63];
  logic prog_lvl;
  logic line_lvl;
  logic rise;
  logic edge_seen;
  logic frame_ok;
  logic is_wr;
  logic is_rd;
  logic mem_we;
  logic [5:0] wa;
  logic [5:0] ra;
  logic [`MPF_PAY_BITS-1:0] wdat;
  logic [31:0] mem_wd;
  logic [31:0] rword;
  logic [31:0] reply;

  // pins cross into hclk through three stages // R16
  mpf_sync u_prog (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(low_voltage_program_pin),
    .q(prog_lvl)
  );
  mpf_sync u_line (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(shared_output_line_i),
    .q(line_lvl)
  );

  assign rise = line_lvl && !s_q.line_p;
  assign edge_seen = line_lvl ^ s_q.line_p;
  assign frame_ok = !s_q.err && (s_q.crc == '0); // R7
  assign is_wr = (s_q.nb == L_WR) && !s_q.sh[`MPF_WR_RW]; // R2
  assign is_rd = (s_q.nb == L_RD) && s_q.sh[`MPF_RD_RW]; // R2
  assign wa = s_q.sh[`MPF_WR_ADDR_LSB +: `MPF_ADDR_BITS]; // R3
  assign ra = s_q.sh[`MPF_RD_ADDR_LSB +: `MPF_ADDR_BITS]; // R3
  // top six data bits are dropped, ecc is regenerated here // R5
  assign wdat = s_q.sh[`MPF_WR_DATA_LSB +: `MPF_PAY_BITS]; // R4
  assign mem_wd = {mpf_pkg::ecc_gen(wdat), wdat}; // R5
  assign mem_we = (s_q.st == mpf_pkg::ST_DONE) && prog_lvl && s_q.rel && frame_ok && is_wr; // R16
  // never-written words read as zero so the line never carries unknowns
  assign rword = s_q.vld[ra] ? mem[ra] : '0;
  assign reply = {4'h0,
                  (mpf_pkg::ecc_gen(rword[`MPF_PAY_BITS-1:0]) == rword[31:`MPF_PAY_BITS]) ?
                  `MPF_ECC_OK : `MPF_ECC_BAD,
                  rword[`MPF_PAY_BITS-1:0]}; // R6

  always_ff @(posedge hclk) begin
    if (mem_we) mem[wa] <= mem_wd;
  end

  always_comb begin
    logic bitv;
    logic acc;
    logic [`MPF_EV_N-1:0] ev;
    logic [`MPF_EV_N-1:0] clr;
    bitv = 1'b0;
    acc = 1'b0;
    ev = '0;
    clr = '0;
    s_d = s_q;
    s_d.line_p = line_lvl;
    if (!prog_lvl) begin
      // back to normal output drive
      s_d.rel = 1'b0;
      s_d.rcnt = '0;
      s_d.loe = 1'b1;
      s_d.lo = 1'b0;
      s_d.st = mpf_pkg::ST_IDLE;
      s_d.lcnt = '0;
    end else if (!s_q.rel) begin
      s_d.rcnt = s_q.rcnt + 1'b1;
      if (s_q.rcnt == C_DIS - 1'b1) begin
        s_d.rel = 1'b1; // R12
        s_d.loe = 1'b0; // R12
        ev[`MPF_EV_REL] = 1'b1;
      end
    end else begin
      case (s_q.st)
        mpf_pkg::ST_IDLE: begin
          if (line_lvl) s_d.lcnt = '0;
          else if (s_q.lcnt != C_LOW) s_d.lcnt = s_q.lcnt + 1'b1;
          // first coded edge only counts after a full low hold // R15
          if (rise && s_q.lcnt == C_LOW && s_q.ctrl) begin
            s_d.st = mpf_pkg::ST_BIT;
            s_d.nb = 6'h01;
            s_d.sh = '0; // R1
            s_d.cnt = '0;
            s_d.crc = `MPF_CRC_INIT; // R8
            s_d.err = 1'b0;
          end
        end
        mpf_pkg::ST_BIT: begin
          s_d.cnt = s_q.cnt + 1'b1;
          // boundary edges fall inside the blind window // R10
          if (edge_seen && s_q.cnt >= C_WIN) begin
            bitv = !line_lvl; // R9
            s_d.sh = {s_q.sh[`MPF_WR_LEN-2:0], bitv}; // R9
            s_d.cnt = '0;
            if (s_q.nb == L_WR) s_d.err = 1'b1;
            else s_d.nb = s_q.nb + 1'b1;
            if (s_q.nb < L_SYNC) begin
              if (bitv) s_d.err = 1'b1; // R1
            end else begin
              s_d.crc = mpf_pkg::crc_step(s_q.crc, bitv); // R8
            end
          end else if (s_q.cnt == C_TO) begin
            s_d.st = mpf_pkg::ST_DONE; // R10
          end
        end
        mpf_pkg::ST_DONE: begin
          s_d.st = mpf_pkg::ST_IDLE;
          s_d.lcnt = '0;
          if (s_q.err) begin
            ev[`MPF_EV_FMT] = 1'b1;
          end else if (s_q.crc != '0) begin
            ev[`MPF_EV_CRC] = 1'b1; // R16
          end else if (is_wr) begin
            ev[`MPF_EV_WR] = 1'b1;
            s_d.vld[wa] = 1'b1;
            s_d.last = {1'b0, wa};
          end else if (is_rd) begin
            s_d.st = mpf_pkg::ST_WAIT; // R17
            s_d.cnt = '0;
            s_d.tx = {2'h0, reply}; // R17
            s_d.last = {1'b1, ra};
          end else begin
            ev[`MPF_EV_FMT] = 1'b1;
          end
        end
        mpf_pkg::ST_WAIT: begin
          // frame end was seen a bit late, one more bit gives turnaround
          s_d.cnt = s_q.cnt + 1'b1;
          if (s_q.cnt == C_BIT - 1'b1) begin
            s_d.st = mpf_pkg::ST_TX; // R17
            s_d.cnt = '0;
            s_d.half = 1'b0;
            s_d.tn = L_TX;
            s_d.loe = 1'b1;
            s_d.lo = s_q.tx[`MPF_TX_LEN-1]; // R9
          end
        end
        mpf_pkg::ST_TX: begin
          s_d.cnt = s_q.cnt + 1'b1;
          if (s_q.cnt == C_HALF - 1'b1) begin
            s_d.cnt = '0;
            if (!s_q.half) begin
              s_d.half = 1'b1;
              s_d.lo = !s_q.tx[`MPF_TX_LEN-1]; // R9
            end else begin
              s_d.half = 1'b0;
              s_d.tx = {s_q.tx[`MPF_TX_LEN-2:0], 1'b0};
              s_d.tn = s_q.tn - 1'b1;
              if (s_q.tn == 6'h01) begin
                s_d.loe = 1'b0;
                s_d.st = mpf_pkg::ST_IDLE;
                s_d.lcnt = '0;
                ev[`MPF_EV_RD] = 1'b1;
              end else begin
                s_d.lo = s_q.tx[`MPF_TX_LEN-2]; // R9
              end
            end
          end
        end
        default: s_d.st = mpf_pkg::ST_IDLE;
      endcase
    end

    // ahb-lite slave, data phase follows the captured address phase
    acc = hsel && htrans[1] && hready;
    s_d.wpend = acc && hwrite && (hsize == `MPF_HSIZE_WORD);
    s_d.rdy = 1'b1;
    if (acc) s_d.ha = haddr[7:0];
    if (acc && !hwrite) begin
      case (haddr[7:0])
        `MPF_CTRL_OFS: s_d.rd = 32'(s_q.ctrl);
        `MPF_STAT_OFS: s_d.rd = 32'(s_q.sts);
        `MPF_IEN_OFS: s_d.rd = 32'(s_q.ien);
        `MPF_LAST_OFS: s_d.rd = 32'({prog_lvl, s_q.rel, s_q.last});
        default: s_d.rd = '0;
      endcase
    end
    if (s_q.wpend) begin
      case (s_q.ha)
        `MPF_CTRL_OFS: s_d.ctrl = hwdata[0];
        `MPF_IEN_OFS: s_d.ien = hwdata[`MPF_EV_N-1:0];
        `MPF_ICLR_OFS: clr = hwdata[`MPF_EV_N-1:0];
        default: ;
      endcase
    end
    // a new event beats a clear in the same cycle
    s_d.sts = (s_q.sts & ~clr) | ev;
    s_d.irq = |(s_d.sts & s_d.ien);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.loe <= 1'b1;
      s_q.ctrl <= `MPF_CTRL_RST;
      s_q.rdy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata = s_q.rd;
  assign hreadyout = s_q.rdy;
  assign hresp = 1'b0 & s_q.rdy;
  assign shared_output_line_o = s_q.lo;
  assign shared_output_line_oe = s_q.loe;
  assign irq = s_q.irq;

  // helper: cycles since the enable level was seen high
  localparam int A_DIS = DIS_CYC;
  localparam int A_HALF = BIT_CYC / 2;
  localparam int A_HLO = A_HALF - 1;
  localparam int A_HHI = A_HALF + 1;
  logic [TW:0] a_pc;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) a_pc <= '0;
    else if (!prog_lvl) a_pc <= '0;
    else if (a_pc != '1) a_pc <= a_pc + 1'b1;
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_rel_win;
    $rose(s_q.rel) |-> (a_pc >= A_DIS - 1) && (a_pc <= A_DIS + 1);
  endproperty
  a_rel_win: assert property (p_rel_win) else $error("driver release outside window"); // R12

  property p_rel_hiz;
    (s_q.rel && s_q.st != mpf_pkg::ST_TX) |-> !shared_output_line_oe;
  endproperty
  a_rel_hiz: assert property (p_rel_hiz) else $error("line driven while listening"); // R12

  property p_wr_sync;
    mem_we |-> (s_q.sh[`MPF_WR_LEN-1 -: `MPF_SYNC_BITS] == '0);
  endproperty
  a_wr_sync: assert property (p_wr_sync) else $error("write taken without zero sync"); // R1

  property p_wr_fmt;
    mem_we |=> s_q.sts[`MPF_EV_WR] && (s_q.last == {1'b0, $past(wa)}) && (s_q.st == mpf_pkg::ST_IDLE);
  endproperty
  a_wr_fmt: assert property (p_wr_fmt) else $error("write frame layout wrong"); // R2 R3 R4

  property p_wr_ecc;
    mem_we |=> s_q.vld[$past(wa)] && (mem[$past(wa)][25:0] == $past(s_q.sh[28:3]))
      && (mem[$past(wa)][31:26] == mpf_pkg::ecc_gen($past(s_q.sh[28:3])));
  endproperty
  a_wr_ecc: assert property (p_wr_ecc) else $error("stored word not payload plus ecc"); // R5

  property p_crc_drop;
    (s_q.st == mpf_pkg::ST_DONE && s_q.crc != '0) |-> !mem_we ##1 (s_q.st != mpf_pkg::ST_WAIT);
  endproperty
  a_crc_drop: assert property (p_crc_drop) else $error("bad crc frame acted on"); // R7 R16

  property p_reply_fmt;
    (s_q.st == mpf_pkg::ST_WAIT && s_d.st == mpf_pkg::ST_TX) |=>
      (s_q.tx[33:28] == '0) && shared_output_line_oe && (shared_output_line_o == 1'b0);
  endproperty
  a_reply_fmt: assert property (p_reply_fmt) else $error("reply header wrong"); // R6 R17

  property p_mid_edge;
    (s_q.st == mpf_pkg::ST_TX && !s_q.half) ##1 s_q.half |-> shared_output_line_o != $past(shared_output_line_o);
  endproperty
  a_mid_edge: assert property (p_mid_edge) else $error("no mid-bit transition"); // R9

  property p_half_len;
    @(posedge hclk) disable iff (!hresetn || !prog_lvl)
      $rose(s_q.half) |-> ##[A_HLO:A_HHI] $fell(s_q.half);
  endproperty
  a_half_len: assert property (p_half_len) else $error("reply half symbol length wrong"); // R10

  property p_irq;
    s_q.irq == |(s_q.sts & s_q.ien);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level mismatch");

  c_release: cover property ($rose(s_q.rel));
  c_write: cover property (mem_we);
  c_read: cover property (s_q.st == mpf_pkg::ST_TX ##1 s_q.st == mpf_pkg::ST_IDLE);
  c_crc_bad: cover property ($rose(s_q.sts[`MPF_EV_CRC]));
endmodule // mpf_port

// File: verification/mpf_ctl_model.sv
// Purpose: programming controller model on the shared line
// Assumes: device has released the line before a frame
// Notes: holds the line low between frames, steps aside during replies
`timescale 1ns/10ps
module mpf_ctl_model #(
  parameter int BIT_CYC = 40,
  parameter int LOW_HOLD = 10
) (
  input wire logic hclk,
  input wire logic pen,
  input wire logic dev_oe,
  input wire logic line,
  output logic drv,
  output logic drv_en
);
  logic drv_q;
  // never fights the device while it owns the line
  assign drv_en = pen & ~dev_oe;
  assign drv = drv_q;
  initial drv_q = 1'b0;

  task automatic send(input logic [43:0] f, input int n);
    drv_q <= 1'b0;
    repeat (LOW_HOLD) @(posedge hclk);
    for (int i = n - 1; i >= 0; i--) begin
      drv_q <= f[i];
      repeat (BIT_CYC / 2) @(posedge hclk);
      drv_q <= ~f[i];
      repeat (BIT_CYC / 2) @(posedge hclk);
    end
    drv_q <= 1'b0;
  endtask

  task automatic recv(output logic [33:0] r, output bit ok);
    int t;
    t = 0;
    ok = 0;
    r = '0;
    while (dev_oe !== 1'b1 && t < 8 * BIT_CYC) begin
      @(posedge hclk);
      t++;
    end
    if (t < 8 * BIT_CYC) begin
      ok = 1;
      // sample mid first half, away from both edges
      repeat (BIT_CYC / 4) @(posedge hclk);
      for (int i = 33; i >= 0; i--) begin
        r[i] = line;
        repeat (BIT_CYC) @(posedge hclk);
      end
    end
  endtask
endmodule // mpf_ctl_model

// File: verification/test_manchester_program_frame_port.sv
// Purpose: self-checking bench of the frame port
// Assumes: shortened bit, release and low-hold counts
// Notes: a reference memory predicts every read reply
`timescale 1ns/10ps
module test_manchester_program_frame_port;
  localparam int B = 40;
  localparam int DIS = 20;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, pen, line, dut_o, dut_oe, irq, drv, drv_en, pat;
  logic [31:0] haddr, hwdata, hrdata, v, d, seed;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [5:0] a;
  logic [31:0] mem [64];
  logic [5:0] wq[$];
  logic [7:0] ofs [4] = '{8'h00, 8'h04, 8'h08, 8'h14};
  logic [31:0] rst_v [4] = '{32'h1, 32'h0, 32'h0, 32'h0};
  int err_total, checked, t;

  assign hready = hreadyout;
  // undriven line wanders so stale levels are never trusted
  assign line = dut_oe ? dut_o : (drv_en ? drv : pat);
  always #10 hclk = ~hclk;
  always @(posedge hclk) pat <= ~pat;

  mpf_port #(.BIT_CYC(B), .DIS_CYC(DIS), .LOW_CYC(4)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .low_voltage_program_pin(pen),
    .shared_output_line_i(line), .shared_output_line_o(dut_o), .shared_output_line_oe(dut_oe), .irq(irq));
  mpf_ctl_model #(.BIT_CYC(B), .LOW_HOLD(10)) ctl (.hclk(hclk), .pen(pen), .dev_oe(dut_oe), .line(line),
    .drv(drv), .drv_en(drv_en));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [2:0] crc3(input logic [40:0] m, input int n);
    logic [2:0] c;
    logic f;
    c = 3'h7;
    for (int i = n - 1; i >= 0; i--) begin
      f = c[2] ^ m[i];
      c = {c[1], c[0] ^ f, f};
    end
    return c;
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] wd, input logic [2:0] sz,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, ad};
    hwrite <= wr;
    hsize <= sz;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    logic [31:0] x;
    ahb(1'b1, ad, wd, 3'h2, x);
  endtask

  task automatic rchk(input string what, input logic [7:0] ad, input logic [31:0] exp);
    logic [31:0] x;
    ahb(1'b0, ad, 32'h0, 3'h2, x);
    chk(what, x, exp);
  endtask

  task automatic wframe(input logic [5:0] ad, input logic [31:0] wd, input logic bad);
    logic [38:0] m;
    m = {1'b0, ad, wd};
    ctl.send({2'b00, m, crc3({2'h0, m}, 39) ^ {2'h0, bad}}, 44);
    repeat (3 * B) @(posedge hclk);
    if (!bad) mem[ad] = wd & 32'h03ffffff;
  endtask

  task automatic rframe(input logic [5:0] ad);
    logic [33:0] r;
    bit ok;
    ctl.send({32'h0, 2'b00, 1'b1, ad, crc3({34'h0, 1'b1, ad}, 7)}, 12);
    ctl.recv(r, ok);
    chk("reply seen", {31'h0, ok}, 32'h1);
    chk("reply sync", {30'h0, r[33:32]}, 32'h0);
    chk("reply data", r[31:0] & 32'h0fffffff, mem[ad]);
    chk("reply length", {31'h0, dut_oe}, 32'h0);
    repeat (2 * B) @(posedge hclk);
  endtask

  initial begin
    repeat (40000) @(posedge hclk);
    err_total++;
    results();
  end

  initial begin
    hclk = 0;
    hresetn = 0;
    hsel = 0;
    haddr = 0;
    htrans = 0;
    hwrite = 0;
    hsize = 3'h2;
    hwdata = 0;
    pen = 0;
    pat = 0;
    err_total = 0;
    checked = 0;
    seed = 32'h1196;
    for (int i = 0; i < 64; i++) mem[i] = '0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("hreadyout", {31'h0, hreadyout}, 32'h1);
    chk("hresp", {31'h0, hresp}, 32'h0);
    chk("line enable", {31'h0, dut_oe}, 32'h1);
    for (int i = 0; i < 4; i++) rchk("reset value", ofs[i], rst_v[i]);
    ahb(1'b1, 8'h08, 32'h1f, 3'h0, v);
    rchk("byte write", 8'h08, 32'h0);
    wr(8'h08, 32'h1f);
    rchk("enable", 8'h08, 32'h1f);
    $display("test registers done");

    pen <= 1'b1;
    t = 0;
    @(posedge hclk);
    while (dut_oe !== 1'b0 && t < 200) begin
      @(posedge hclk);
      t++;
    end
    chk("release time", 32'(t >= DIS && t <= DIS + 6), 32'h1);
    rchk("status", 8'h04, 32'h10);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(8'h0c, 32'h1f);
    rchk("status", 8'h04, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    repeat (2 * DIS) @(posedge hclk);
    $display("test release done");

    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      a = seed[5:0];
      seed = lfsr(seed);
      d = seed | 32'hfc000000;
      wq.push_back(a);
      wframe(a, d, 1'b0);
    end
    rchk("status", 8'h04, 32'h1);
    rchk("last", 8'h10, {23'h0, 3'h6, a});
    wr(8'h0c, 32'h1f);
    $display("test write done");

    wq.push_back(6'h3f);
    foreach (wq[i]) rframe(wq[i]);
    rchk("status", 8'h04, 32'h2);
    rchk("last", 8'h10, {23'h0, 3'h7, 6'h3f});
    wr(8'h0c, 32'h1f);
    $display("test read done");

    wframe(wq[0], ~mem[wq[0]], 1'b1);
    rchk("status", 8'h04, 32'h4);
    rframe(wq[0]);
    wr(8'h08, 32'h02);
    @(posedge hclk);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(8'h08, 32'h08);
    @(posedge hclk);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(8'h0c, 32'h1f);
    // second sync bit set: frame must end as a format error
    ctl.send({32'h0, 2'b01, 1'b1, wq[0], crc3({34'h0, 1'b1, wq[0]}, 7)}, 12);
    repeat (3 * B) @(posedge hclk);
    rchk("status", 8'h04, 32'h8);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(8'h0c, 32'h1f);
    // receiver switched off: a valid read gets no reply
    wr(8'h00, 32'h0);
    ctl.send({32'h0, 2'b00, 1'b1, wq[0], crc3({34'h0, 1'b1, wq[0]}, 7)}, 12);
    repeat (3 * B) @(posedge hclk);
    chk("rx off reply", {31'h0, dut_oe}, 32'h0);
    rchk("status", 8'h04, 32'h0);
    $display("test crc done");

    pen <= 1'b0;
    repeat (8) @(posedge hclk);
    chk("line enable", {31'h0, dut_oe}, 32'h1);
    $display("test exit done");
    results();
  end
endmodule // test_manchester_program_frame_port
